//--- logic/rtc_link_defs.svh
/*
  Constants shared by both ends of the serial clock read link.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef RTC_LINK_DEFS_SVH
`define RTC_LINK_DEFS_SVH

`define CMD_READ_BIT 7
`define CMD_ADDR_MSB 5
`define CMD_RESERVED 8'h17
`define SECONDS_ADDR 5'h00
`define SECONDS_RESET 8'h00
`define REG_RESET 8'h00
`define BITS_PER_BYTE 4'h8
`define SYS_CLK_HZ 10000000
`define LINK_CLK_PERIOD_NS 800
`define LINK_HALF_CYCLES 4

`endif

//--- logic/rtc_link_pkg.sv
/*
  Types shared by both ends of the link.
  Assumes rtc_link_defs.svh is on the include path.
*/
`default_nettype none
`include "rtc_link_defs.svh"
package rtc_link_pkg;
  typedef enum logic [1:0] {
    idle_type_s = 2'b00,
    cmd_type_s = 2'b01,
    data_type_s = 2'b11,
    hold_type_s = 2'b10
  } phase_type;
  typedef enum logic [2:0] {
    m_idle = 3'b000,
    m_low = 3'b001,
    m_high = 3'b011,
    m_done = 3'b010,
    m_end = 3'b110
  } master_state_type;
endpackage
`default_nettype wire

//--- logic/rtc_link_if.sv
/*
  Four-wire serial link between the master and the clock device.
  Assumes both ends run on the same sys_clk domain or sample the pins.
*/
`default_nettype none
interface rtc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  // Resolved line level; weak pull-up when nobody drives
  logic dout;
  assign dout = dout_oe ? dout_o : 1'b1;
  modport device (input sclk, input cs_n, input din,
    output dout_o, output dout_oe);
  modport master (output sclk, output cs_n, output din, input dout);
endinterface
`default_nettype wire

//--- logic/rtc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and synchronous reset.
*/
`default_nettype none
module rtc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // rtc_fifo
`default_nettype wire

//--- logic/rtc_spi_device.sv
/*
  Device end: command capture and read-data output path of the clock.
  Assumes the link pins arrive asynchronously; a power-good level
  stands in for the supply threshold detector.
*/
`default_nettype none
`include "rtc_link_defs.svh"
module rtc_spi_device #(
  parameter int NUM_REGS = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic supply_ok,
  input wire logic tick_1s,
  rtc_link_if.device link,
  output logic [7:0] last_command,
  output logic reserved_hit
);
  initial begin
    if (NUM_REGS < 2 || NUM_REGS > 32) begin
      $error("NUM_REGS out of range");
    end
  end

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] din_s;
    rtc_link_pkg::phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] cmd;
    logic [7:0] shreg;
    logic [4:0] addr;
    logic dout_o;
    logic dout_oe;
    logic [7:0] seconds;
    logic reserved_hit;
  } state_type;

  state_type cur;
  state_type next_cur;
  logic [7:0] regs [NUM_REGS];
  logic rst_all;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic [7:0] rd_byte;

  assign rst_all = srst || !supply_ok;
  // Edges detected where stages two and three disagree
  assign sclk_rise = cur.sclk_s[1] && cur.sclk_s[2] == 1'b0
    && cur.sclk_s[1] != cur.sclk_s[2];
  assign sclk_fall = !cur.sclk_s[1] && cur.sclk_s[2];
  assign cs_high = cur.cs_s[1] && cur.cs_s[2];
  // Seconds live in its own counter; other locations read as defaults
  assign rd_byte = (cur.addr == `SECONDS_ADDR) ? cur.seconds
    : regs[cur.addr];

  always_comb begin
    next_cur = cur;
    next_cur.sclk_s = {cur.sclk_s[1:0], link.sclk};
    next_cur.cs_s = {cur.cs_s[1:0], link.cs_n};
    next_cur.din_s = {cur.din_s[1:0], link.din};
    if (tick_1s) begin
      next_cur.seconds = cur.seconds + 8'h01;
    end
    if (cs_high) begin
      next_cur.phase = rtc_link_pkg::idle_type_s;
      next_cur.dout_oe = 1'b0;
      next_cur.bit_cnt = 4'h0;
    end else begin
      unique case (cur.phase)
        rtc_link_pkg::idle_type_s: begin
          next_cur.phase = rtc_link_pkg::cmd_type_s;
          next_cur.bit_cnt = 4'h0;
          next_cur.dout_oe = 1'b0;
        end
        rtc_link_pkg::cmd_type_s: begin
          if (sclk_rise) begin
            next_cur.cmd = {cur.cmd[6:0], cur.din_s[2]};
            next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          end
          // Eighth falling edge ends the command byte
          if (sclk_fall && cur.bit_cnt == `BITS_PER_BYTE) begin
            next_cur.addr = cur.cmd[4:0];
            if (cur.cmd[`CMD_READ_BIT]) begin
              next_cur.phase = rtc_link_pkg::data_type_s;
              next_cur.bit_cnt = 4'h0;
            end else begin
              next_cur.phase = rtc_link_pkg::hold_type_s;
              if (cur.cmd == `CMD_RESERVED) begin
                next_cur.reserved_hit = 1'b1;
              end
            end
          end
        end
        rtc_link_pkg::data_type_s: begin
          // Bit load on entry and on every falling edge
          if (cur.bit_cnt == 4'h0) begin
            next_cur.dout_oe = 1'b1;
            next_cur.dout_o = rd_byte[7];
            next_cur.shreg = {rd_byte[6:0], 1'b0};
            next_cur.bit_cnt = 4'h1;
          end else if (sclk_fall) begin
            if (cur.bit_cnt == `BITS_PER_BYTE) begin
              next_cur.addr = cur.addr + 5'h01;
              next_cur.bit_cnt = 4'h0;
            end else begin
              next_cur.dout_o = cur.shreg[7];
              next_cur.shreg = {cur.shreg[6:0], 1'b0};
              next_cur.bit_cnt = cur.bit_cnt + 4'h1;
            end
          end
        end
        rtc_link_pkg::hold_type_s: begin
          // Write path lives elsewhere; output stays off
          next_cur.dout_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      cur <= '0;
      cur.sclk_s <= 3'b111;
      cur.cs_s <= 3'b111;
      cur.seconds <= `SECONDS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs[i] <= `REG_RESET;
    end
  end

  assign link.dout_o = cur.dout_o;
  assign link.dout_oe = cur.dout_oe;
  assign last_command = cur.cmd;
  assign reserved_hit = cur.reserved_hit;
endmodule // rtc_spi_device
`default_nettype wire

//--- logic/rtc_spi_master.sv
/*
  Master end: sends a read command, then clocks bytes into a FIFO.
  Assumes dout is resolved by the interface and arrives unsynchronised.
*/
`default_nettype none
`include "rtc_link_defs.svh"
module rtc_spi_master #(
  parameter int HALF = `LINK_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  rtc_link_if.master link,
  input wire logic start,
  input wire logic [7:0] command,
  input wire logic [7:0] byte_count,
  output logic busy,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  initial begin
    if (HALF < 1 || HALF > 255) begin
      $error("HALF out of range");
    end
  end
  typedef struct packed {
    rtc_link_pkg::master_state_type st;
    logic [7:0] div;
    logic [3:0] bit_cnt;
    logic [7:0] bytes_left;
    logic in_cmd;
    logic [7:0] shreg;
    logic [2:0] dout_s;
    logic sclk;
    logic cs_n;
    logic din;
    logic push;
    logic [7:0] push_data;
  } state_type;
  state_type cur;
  state_type next_cur;
  logic fifo_ready;
  logic tick;
  assign tick = cur.div == 8'(HALF - 1);

  always_comb begin
    next_cur = cur;
    next_cur.dout_s = {cur.dout_s[1:0], link.dout};
    next_cur.push = 1'b0;
    next_cur.div = tick ? 8'h00 : cur.div + 8'h01;
    unique case (cur.st)
      rtc_link_pkg::m_idle: begin
        next_cur.div = 8'h00;
        if (start) begin
          next_cur.st = rtc_link_pkg::m_low;
          next_cur.cs_n = 1'b0;
          // Opening fall launches the first command bit
          next_cur.sclk = 1'b0;
          next_cur.in_cmd = 1'b1;
          next_cur.shreg = command;
          next_cur.bit_cnt = 4'h0;
          next_cur.bytes_left = byte_count;
          next_cur.din = command[7];
        end
      end
      rtc_link_pkg::m_low: begin
        // Stall before each data bit while the FIFO has no room
        if (tick && (cur.in_cmd || fifo_ready)) begin
          next_cur.sclk = 1'b1;
          next_cur.st = rtc_link_pkg::m_high;
        end
      end
      rtc_link_pkg::m_high: begin
        if (tick) begin
          next_cur.sclk = 1'b0;
          next_cur.bit_cnt = cur.bit_cnt + 4'h1;
          next_cur.st = rtc_link_pkg::m_low;
          if (cur.in_cmd) begin
            next_cur.shreg = {cur.shreg[6:0], 1'b0};
            next_cur.din = cur.shreg[6];
          end else begin
            // Sample late in the high phase: synchroniser lag on both ends
            next_cur.shreg = {cur.shreg[6:0], cur.dout_s[2]};
          end
          if (cur.bit_cnt == 4'h7) begin
            next_cur.bit_cnt = 4'h0;
            next_cur.in_cmd = 1'b0;
            if (!cur.in_cmd) begin
              next_cur.push = 1'b1;
              next_cur.push_data = {cur.shreg[6:0], cur.dout_s[2]};
              next_cur.bytes_left = cur.bytes_left - 8'h01;
            end
            if (!cur.in_cmd && cur.bytes_left == 8'h01
                || cur.in_cmd && byte_count == 8'h00) begin
              next_cur.st = rtc_link_pkg::m_done;
            end
          end
        end
      end
      rtc_link_pkg::m_done: begin
        if (tick) begin
          next_cur.cs_n = 1'b1;
          next_cur.sclk = 1'b1;
          next_cur.st = rtc_link_pkg::m_end;
        end
      end
      rtc_link_pkg::m_end: begin
        if (tick) begin
          next_cur.st = rtc_link_pkg::m_idle;
        end
      end
      default: begin
        next_cur.st = rtc_link_pkg::m_idle;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur <= '0;
      cur.cs_n <= 1'b1;
      cur.sclk <= 1'b1;
      cur.dout_s <= 3'b111;
    end else begin
      cur <= next_cur;
    end
  end

  rtc_fifo #(.WIDTH(8), .DEPTH(16)) rtc_fifo_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(cur.push),
    .in_ready(fifo_ready),
    .in_data(cur.push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign link.sclk = cur.sclk;
  assign link.cs_n = cur.cs_n;
  assign link.din = cur.din;
  assign busy = cur.st != rtc_link_pkg::m_idle;
endmodule // rtc_spi_master
`default_nettype wire

//--- testbench/rtc_link_properties.sv
/*
  Concurrent checks on the four-wire link between master and device.
  Assumes one sys_clk domain and an instance beside the link interface.
*/
`default_nettype none
module rtc_link_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q;
  logic [8:0] falls;
  logic rd;
  // ********************************
  // Edge bookkeeping
  // ********************************
  always_ff @(posedge sys_clk) begin
    sclk_q <= sclk;
    if (srst || cs_n) begin
      falls <= 9'h000;
      rd <= 1'b0;
    end else begin
      if (sclk_q && !sclk) begin
        falls <= falls + 9'h001;
      end
      // First command bit tells a read from anything else
      if (!sclk_q && sclk && falls == 9'h001) begin
        rd <= din;
      end
    end
  end
  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  sequence cmd_read_done;
    $fell(sclk) && !cs_n && falls == 9'h008 && rd;
  endsequence
  sequence low_half;
    !sclk[*4] ##1 sclk;
  endsequence
  a_oe_idle_off: assert property (cs_n[*8] |-> !dout_oe)
    else $error("data output driven while deselected");
  a_oe_cmd_phase: assert property (
    !cs_n && falls < 9'h008 && !$past(cs_n, 8) |-> !dout_oe)
    else $error("data output driven during command bits");
  a_oe_read_start: assert property (
    cmd_read_done |-> ##[1:10] dout_oe)
    else $error("read data not driven after eighth fall");
  a_oe_nonread_off: assert property (
    !cs_n && !rd && falls > 9'h001 |-> !dout_oe)
    else $error("data output driven without a read command");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:8] !dout_oe)
    else $error("data output still driven after deselect");
  a_sclk_idle_high: assert property (cs_n && $past(cs_n) |-> sclk)
    else $error("serial clock not idle high while deselected");
  a_din_hold: assert property ($rose(sclk) && !cs_n |-> $stable(din))
    else $error("command bit changed at sampling edge");
  a_sclk_half_low: assert property ($fell(sclk) && !cs_n |-> low_half)
    else $error("serial clock low phase not four cycles");
  a_whole_bytes: assert property (
    $rose(cs_n) |-> falls[2:0] == 3'h1 && falls > 9'h009)
    else $error("transfer ended inside a byte");
endmodule // rtc_link_properties
`default_nettype wire

//--- testbench/spi_rtc_read_output_path_test.sv
/*
  Bench joining master and clock device across the link interface.
  Assumes the logic/ files and the checker are compiled first.
*/
`default_nettype none
module spi_rtc_read_output_path_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst, abort, supply_ok, tick_1s, start, out_ready;
  logic busy, out_valid, reserved_hit, oe_seen;
  logic [7:0] command, byte_count, out_data, last_command, mon_cmd, mon_dat;
  int n_mismatch, comparisons, mon_bits;
  rtc_link_if link ();
  rtc_link_properties rtc_link_properties_inst (.sys_clk(sys_clk),
    .srst(srst || abort), .sclk(link.sclk), .cs_n(link.cs_n),
    .din(link.din), .dout_oe(link.dout_oe));
  rtc_spi_device rtc_spi_device_inst (.sys_clk(sys_clk), .srst(srst),
    .supply_ok(supply_ok), .tick_1s(tick_1s), .link(link),
    .last_command(last_command), .reserved_hit(reserved_hit));
  // Own master reset lets a transfer be cut off midway
  rtc_spi_master rtc_spi_master_inst (.sys_clk(sys_clk),
    .srst(srst || abort), .link(link), .start(start), .command(command),
    .byte_count(byte_count), .busy(busy), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  // ********************************
  // Wire monitor
  // ********************************
  always @(negedge link.cs_n) mon_bits = 0;
  always @(posedge link.sclk) begin
    if (link.cs_n === 1'b0) begin
      mon_bits++;
      if (mon_bits <= 8) mon_cmd = {mon_cmd[6:0], link.din};
    end
  end
  // Data bits read just before the launching fall, clear of the launch
  always @(negedge link.sclk) begin
    if (link.cs_n === 1'b0 && link.dout_oe === 1'b1 && mon_bits > 8)
      mon_dat = {mon_dat[6:0], link.dout};
  end
  always @(posedge sys_clk) if (link.dout_oe === 1'b1) oe_seen = 1'b1;
  // ********************************
  // Tasks
  // ********************************
  task automatic check(input string name, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] cmd, n, input bit wait_end);
    @(negedge sys_clk);
    oe_seen = 1'b0;
    command = cmd;
    byte_count = n;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    for (int i = 0; i < 3000 && wait_end && busy !== 1'b0; i++) begin
      @(negedge sys_clk);
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    for (int i = 0; i < 100 && out_valid !== 1'b1; i++) @(negedge sys_clk);
    check("out_valid", {7'h00, out_valid}, 8'h01);
    check("out_data", out_data, exp);
    out_ready = 1'b1;
    @(negedge sys_clk);
    out_ready = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic t_default;
    send(8'h80, 8'h01, 1'b1);
    pop(8'h00);
    check("command", mon_cmd, 8'h80);
    check("last_command", last_command, 8'h80);
    check("oe_seen", {7'h00, oe_seen}, 8'h01);
    $display("t_default done");
  endtask
  task automatic t_burst;
    repeat (5) begin
      @(negedge sys_clk);
      tick_1s = 1'b1;
      @(negedge sys_clk);
      tick_1s = 1'b0;
    end
    send(8'h80, 8'h01, 1'b1);
    pop(8'h05);
    check("wire_byte", mon_dat, 8'h05);
    // Reader stalls while sixteen bytes fill the buffer
    send(8'h80, 8'h10, 1'b1);
    for (int i = 0; i < 16; i++) pop(i == 0 ? 8'h05 : 8'h00);
    check("drained", {7'h00, out_valid}, 8'h00);
    $display("t_burst done");
  endtask
  task automatic t_nonread;
    send(8'h05, 8'h01, 1'b1);
    pop(8'hFF);
    check("oe_seen", {7'h00, oe_seen}, 8'h00);
    check("reserved", {7'h00, reserved_hit}, 8'h00);
    send(8'h17, 8'h01, 1'b1);
    pop(8'hFF);
    check("reserved", {7'h00, reserved_hit}, 8'h01);
    @(negedge sys_clk);
    supply_ok = 1'b0;
    repeat (3) @(negedge sys_clk);
    supply_ok = 1'b1;
    check("reserved", {7'h00, reserved_hit}, 8'h00);
    send(8'h80, 8'h01, 1'b1);
    pop(8'h00);
    $display("t_nonread done");
  endtask
  task automatic t_abort;
    send(8'h80, 8'h04, 1'b0);
    repeat (120) @(negedge sys_clk);
    abort = 1'b1;
    repeat (3) @(negedge sys_clk);
    abort = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("oe_abort", {7'h00, link.dout_oe}, 8'h00);
    send(8'h80, 8'h01, 1'b1);
    pop(8'h00);
    check("command", mon_cmd, 8'h80);
    $display("t_abort done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********************************
  // Sequence
  // ********************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {abort, tick_1s, start, out_ready, oe_seen} = 5'h00;
    srst = 1'b1;
    supply_ok = 1'b1;
    command = 8'h00;
    byte_count = 8'h00;
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    t_default();
    t_burst();
    t_nonread();
    t_abort();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule // spi_rtc_read_output_path_test
`default_nettype wire
